// [rtl/psm_pkg.sv]
package psm_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int PC_W = 17;
  localparam int SP_W = 16;
  localparam int RAM_AW = 16;
  localparam int EXT_AW = 24;
  localparam int ROM_AW = 18;
  localparam int AVS_AW = 18;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [15:0] IDX_ACC = 16'hfe00;
  localparam logic [15:0] IDX_SAR = 16'hfe01;
  localparam logic [15:0] IDX_OFFS = 16'hfe02;
  localparam logic [15:0] IDX_STATUS = 16'hfe06;
  localparam logic [15:0] IDX_SPL = 16'hfe0a;
  localparam logic [15:0] IDX_SPH = 16'hfe0b;
  localparam logic [15:0] IDX_PC = 16'hff00;
  localparam logic [15:0] IDX_OPER = 16'hff01;
  localparam logic [15:0] IDX_CMD = 16'hff02;
  localparam logic [15:0] IDX_XADDR = 16'hff03;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int ST_P1 = 1;
  localparam int ST_OV = 2;
  localparam int PCR_BANK = 17;
  localparam int CMD_LEN_LO = 4;
  localparam int CMD_TAKE = 7;
  localparam int CMR_BUSY = 0;
  localparam int CMR_OPT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [SP_W-1:0] RST_SP = 16'h0000;

  // ****************************************************************
  // Address map and vectors.
  // ****************************************************************
  localparam logic [RAM_AW-1:0] RAM9_TOP = 16'hfdff;
  localparam logic [PC_W-1:0] OPT_LO = 17'h1ff00;
  localparam logic [PC_W-1:0] OPT_HI = 17'h1ffff;
  localparam logic [PC_W-1:0] RESET_VEC = 17'h00000;
  localparam logic [PC_W-1:0] VEC_BASE = 17'h00003;
  localparam int VEC_SHIFT = 3;
  localparam logic [3:0] NUM_VEC = 4'ha;
  localparam logic [PC_W-1:0] REL12_LEN = 17'h00002;
  localparam logic [PC_W-1:0] ACCREL_LEN = 17'h00001;

  // ****************************************************************
  // Commands and sequencer states.
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_STEP = 4'h0, CMD_BRCOND = 4'h1, CMD_BR12 = 4'h2, CMD_JUMP = 4'h3,
    CMD_CALL = 4'h4, CMD_CALL12 = 4'h5, CMD_CALLA = 4'h6, CMD_RET = 4'h7,
    CMD_INTR = 4'h8, CMD_LOOKUP = 4'h9, CMD_MUL = 4'ha, CMD_DIV = 4'hb,
    CMD_XLOAD = 4'hc, CMD_XSTORE = 4'hd, CMD_RAMRD = 4'he, CMD_RAMWR = 4'hf
  } psm_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PUSH_LO = 4'h1, ST_PUSH_HI = 4'h2, ST_POP_HI = 4'h3,
    ST_POP_LO = 4'h4, ST_POP_FIN = 4'h5, ST_IND_LO = 4'h6, ST_IND_HI = 4'h7,
    ST_ROM_RD = 4'h8, ST_ROM_FIN = 4'h9, ST_EXT_RD = 4'ha, ST_EXT_FIN = 4'hb,
    ST_EXT_WR = 4'hc, ST_RAM_RD = 4'hd, ST_RAM_FIN = 4'he, ST_RAM_WR = 4'hf
  } psm_state_t;

endpackage

// [rtl/psm_sequencer.sv]
// Behaviour
// - 17-bit program counter plus bank flag
// - Two 128K banks form 256K program space
// - Ordinary step adds length, bank kept
// - Reset and interrupts load vector, clear bank
// - Branch targets: relative, accumulator, absolute forms
// - Return loads high then low stack bytes
// - Return takes bank from low byte bit8
// - Call saves bank+low, then upper nine
// - Bank 0 top 256 bytes not code; counter may still enter them, only flagged
// - Table lookup reads current bank
// - Low data space uses nine-bit words
// - First 128 bytes form 64 pointers
// - Lookup pointer is nine plus eight bits
// - 64K internal, 16M external data spaces
// - Accumulator at FE00, resets to zero
// - Second register at FE01, pairs with accumulator
// - Multiply/divide results span three registers
// - External address top byte from second register
// - Stack pointer pre-increment, post-decrement
`timescale 1ns/1ps
`default_nettype none
module psm_sequencer (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Avalon-MM register slave.
  input wire logic [psm_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program ROM port.
  output logic [psm_pkg::ROM_AW-1:0] rom_addr,
  output logic rom_re,
  input wire logic [7:0] rom_rdata,
  // Internal data RAM port, nine bits wide.
  output logic [psm_pkg::RAM_AW-1:0] ram_addr,
  output logic ram_re,
  output logic ram_we,
  output logic [8:0] ram_wdata,
  input wire logic [8:0] ram_rdata,
  // External data port.
  output logic [psm_pkg::EXT_AW-1:0] ext_addr,
  output logic ext_re,
  output logic ext_we,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  psm_pkg::psm_state_t state_r;
  psm_pkg::psm_state_t state_nxt;
  psm_pkg::psm_cmd_t cmd;
  logic [psm_pkg::PC_W-1:0] pc_r;
  logic [psm_pkg::PC_W-1:0] pc_nxt;
  logic bank_select_flag_r;
  logic bank_nxt;
  logic [psm_pkg::PC_W-1:0] ret_r;
  logic [psm_pkg::PC_W-1:0] ret_nxt;
  logic ret_bank_r;
  logic push_go;
  logic [psm_pkg::SP_W-1:0] sp_r;
  logic [7:0] accumulator_r;
  logic [7:0] second_arith_reg_r;
  logic [7:0] offset_reg_r;
  logic [7:0] status_word_r;
  logic [23:0] oper_r;
  logic [8:0] hi_r;
  logic [7:0] lo_r;
  logic [31:0] readdata_r;
  logic rd_ack_r;
  logic busy;
  logic wr_ok;
  logic cmd_go;
  logic [15:0] idx;
  logic [psm_pkg::PC_W-1:0] len;
  logic [psm_pkg::PC_W-1:0] rel8;
  logic [psm_pkg::PC_W-1:0] rel12;
  logic [psm_pkg::PC_W-1:0] vec;
  logic [23:0] product;
  logic [15:0] quotient;
  logic [15:0] remainder;
  logic ram9;
  logic pc_in_option;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************

  // Registers sit one per aligned word; writes stall while a sequence runs.
  assign idx = avs_address[psm_pkg::AVS_AW-1:2];
  assign busy = (state_r != psm_pkg::ST_IDLE);
  assign wr_ok = avs_write && !busy;
  assign cmd_go = wr_ok && (idx == psm_pkg::IDX_CMD);
  assign cmd = psm_pkg::psm_cmd_t'(avs_writedata[3:0]);
  assign avs_waitrequest = avs_read ? !rd_ack_r : (avs_write && busy);
  assign avs_readdata = readdata_r;

  // Reads answer on the second cycle from a registered copy.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        unique case (idx)
          psm_pkg::IDX_ACC: readdata_r <= {24'h000000, accumulator_r};
          psm_pkg::IDX_SAR: readdata_r <= {24'h000000, second_arith_reg_r};
          psm_pkg::IDX_OFFS: readdata_r <= {24'h000000, offset_reg_r};
          psm_pkg::IDX_STATUS: readdata_r <= {24'h000000, status_word_r};
          psm_pkg::IDX_SPL: readdata_r <= {24'h000000, sp_r[7:0]};
          psm_pkg::IDX_SPH: readdata_r <= {24'h000000, sp_r[15:8]};
          psm_pkg::IDX_PC: readdata_r <= {14'h0000, bank_select_flag_r, pc_r};
          psm_pkg::IDX_OPER: readdata_r <= {8'h00, oper_r};
          psm_pkg::IDX_CMD: readdata_r <= {30'h00000000, pc_in_option, busy};
          psm_pkg::IDX_XADDR: readdata_r <= {8'h00, ext_addr};
          default: readdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Next program address.
  // ****************************************************************

  // Branch offsets are sign extended to the counter width, the accumulator offset zero extended; all sums wrap in 17 bits.
  assign len = {14'h0000, avs_writedata[psm_pkg::CMD_LEN_LO+2:psm_pkg::CMD_LEN_LO]};
  assign rel8 = {{9{oper_r[7]}}, oper_r[7:0]};
  assign rel12 = {{5{oper_r[11]}}, oper_r[11:0]};
  assign vec = psm_pkg::VEC_BASE + (17'(oper_r[3:0]) << psm_pkg::VEC_SHIFT);

  // Select the counter value and any return address for a new command.
  always_comb begin
    pc_nxt = pc_r;
    bank_nxt = bank_select_flag_r;
    ret_nxt = pc_r + len;
    push_go = 1'b0;
    if (cmd_go) begin
      unique case (cmd)
        psm_pkg::CMD_STEP: pc_nxt = pc_r + len;
        psm_pkg::CMD_BRCOND: begin
          pc_nxt = pc_r + len + (avs_writedata[psm_pkg::CMD_TAKE] ? rel8 : 17'h00000);
        end
        psm_pkg::CMD_BR12: pc_nxt = pc_r + psm_pkg::REL12_LEN + rel12;
        psm_pkg::CMD_JUMP: pc_nxt = oper_r[psm_pkg::PC_W-1:0];
        psm_pkg::CMD_CALL: begin
          pc_nxt = oper_r[psm_pkg::PC_W-1:0];
          push_go = 1'b1;
        end
        psm_pkg::CMD_CALL12: begin
          pc_nxt = pc_r + psm_pkg::REL12_LEN + rel12;
          push_go = 1'b1;
        end
        psm_pkg::CMD_CALLA: begin
          pc_nxt = pc_r + psm_pkg::ACCREL_LEN + {9'h000, accumulator_r};
          push_go = 1'b1;
        end
        psm_pkg::CMD_INTR: begin
          if (oper_r[3:0] < psm_pkg::NUM_VEC) begin
            pc_nxt = vec;
            bank_nxt = 1'b0;
            ret_nxt = pc_r;
            push_go = 1'b1;
          end
        end
        default: pc_nxt = pc_r;
      endcase
    end
  end

  // Program counter and bank; a return overwrites both from the stack.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= psm_pkg::RESET_VEC;
      bank_select_flag_r <= 1'b0;
    end else if (state_r == psm_pkg::ST_POP_FIN) begin
      pc_r <= {hi_r, ram_rdata[7:0]};
      bank_select_flag_r <= ram_rdata[8];
    end else begin
      pc_r <= pc_nxt;
      bank_select_flag_r <= bank_nxt;
    end
  end

  // Return address held for the two stack writes.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ret_r <= psm_pkg::RESET_VEC;
      ret_bank_r <= 1'b0;
    end else if (push_go) begin
      ret_r <= ret_nxt;
      ret_bank_r <= bank_select_flag_r;
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************

  // RAM reads and writes by command go below the special register area only; stack and pointer accesses are not checked.
  assign ram9 = (oper_r[15:0] <= psm_pkg::RAM9_TOP);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      psm_pkg::ST_IDLE: begin
        if (push_go) begin
          state_nxt = psm_pkg::ST_PUSH_LO;
        end else if (cmd_go) begin
          unique case (cmd)
            psm_pkg::CMD_RET: state_nxt = psm_pkg::ST_POP_HI;
            psm_pkg::CMD_LOOKUP: state_nxt = psm_pkg::ST_IND_LO;
            psm_pkg::CMD_XLOAD: state_nxt = psm_pkg::ST_EXT_RD;
            psm_pkg::CMD_XSTORE: state_nxt = psm_pkg::ST_EXT_WR;
            psm_pkg::CMD_RAMRD: state_nxt = ram9 ? psm_pkg::ST_RAM_RD : psm_pkg::ST_IDLE;
            psm_pkg::CMD_RAMWR: state_nxt = ram9 ? psm_pkg::ST_RAM_WR : psm_pkg::ST_IDLE;
            default: state_nxt = psm_pkg::ST_IDLE;
          endcase
        end
      end
      psm_pkg::ST_PUSH_LO: state_nxt = psm_pkg::ST_PUSH_HI;
      psm_pkg::ST_POP_HI: state_nxt = psm_pkg::ST_POP_LO;
      psm_pkg::ST_POP_LO: state_nxt = psm_pkg::ST_POP_FIN;
      psm_pkg::ST_IND_LO: state_nxt = psm_pkg::ST_IND_HI;
      psm_pkg::ST_IND_HI: state_nxt = psm_pkg::ST_ROM_RD;
      psm_pkg::ST_ROM_RD: state_nxt = psm_pkg::ST_ROM_FIN;
      psm_pkg::ST_EXT_RD: state_nxt = psm_pkg::ST_EXT_FIN;
      psm_pkg::ST_RAM_RD: state_nxt = psm_pkg::ST_RAM_FIN;
      default: state_nxt = psm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= psm_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stack pointer moves before each save and after each restore.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= psm_pkg::RST_SP;
    end else if (state_r == psm_pkg::ST_PUSH_LO || state_r == psm_pkg::ST_PUSH_HI) begin
      sp_r <= sp_r + 16'h0001;
    end else if (state_r == psm_pkg::ST_POP_HI || state_r == psm_pkg::ST_POP_LO) begin
      sp_r <= sp_r - 16'h0001;
    end else if (wr_ok && idx == psm_pkg::IDX_SPL) begin
      sp_r[7:0] <= avs_writedata[7:0];
    end else if (wr_ok && idx == psm_pkg::IDX_SPH) begin
      sp_r[15:8] <= avs_writedata[7:0];
    end
  end

  // Data captured from RAM for returns and pointer fetches.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_r <= 9'h000;
      lo_r <= psm_pkg::RST_BYTE;
    end else if (state_r == psm_pkg::ST_POP_LO) begin
      hi_r <= ram_rdata;
    end else if (state_r == psm_pkg::ST_IND_HI) begin
      lo_r <= ram_rdata[7:0];
    end
  end

  // ****************************************************************
  // Memory ports.
  // ****************************************************************

  // RAM strobes and address follow the state; pointer n sits at 2n and 2n+1.
  always_comb begin
    ram_addr = sp_r;
    ram_re = 1'b0;
    ram_we = 1'b0;
    ram_wdata = 9'h000;
    unique case (state_r)
      psm_pkg::ST_PUSH_LO, psm_pkg::ST_PUSH_HI: begin
        ram_addr = sp_r + 16'h0001;
        ram_we = 1'b1;
        ram_wdata = (state_r == psm_pkg::ST_PUSH_LO) ? {ret_bank_r, ret_r[7:0]}
                                                     : ret_r[16:8];
      end
      psm_pkg::ST_POP_HI, psm_pkg::ST_POP_LO: ram_re = 1'b1;
      psm_pkg::ST_IND_LO, psm_pkg::ST_IND_HI: begin
        ram_addr = {9'h000, oper_r[5:0], (state_r == psm_pkg::ST_IND_HI)};
        ram_re = 1'b1;
      end
      psm_pkg::ST_RAM_RD: begin
        ram_addr = oper_r[15:0];
        ram_re = 1'b1;
      end
      psm_pkg::ST_RAM_WR: begin
        ram_addr = oper_r[15:0];
        ram_we = 1'b1;
        ram_wdata = {status_word_r[psm_pkg::ST_P1], accumulator_r};
      end
      default: ram_re = 1'b0;
    endcase
  end

  // ROM shows the fetch address, or the lookup pointer inside the current bank.
  always_comb begin
    rom_re = (state_r == psm_pkg::ST_ROM_RD);
    if (rom_re) begin
      rom_addr = {bank_select_flag_r, ram_rdata, lo_r};
    end else begin
      rom_addr = {bank_select_flag_r, pc_r};
    end
  end

  // Option area at the top of bank 0 must never be run as code; entry is only flagged in command register bit 1, not blocked.
  assign pc_in_option = !bank_select_flag_r && pc_r >= psm_pkg::OPT_LO
                        && pc_r <= psm_pkg::OPT_HI;

  // External space takes its top byte from the second register.
  assign ext_addr = {second_arith_reg_r, oper_r[15:0]};
  assign ext_re = (state_r == psm_pkg::ST_EXT_RD);
  assign ext_we = (state_r == psm_pkg::ST_EXT_WR);
  assign ext_wdata = accumulator_r;

  // ****************************************************************
  // Arithmetic registers.
  // ****************************************************************

  assign product = {second_arith_reg_r, accumulator_r} * offset_reg_r;
  assign quotient = (offset_reg_r == 8'h00) ? 16'hffff
                    : {second_arith_reg_r, accumulator_r} / {8'h00, offset_reg_r};
  assign remainder = (offset_reg_r == 8'h00) ? 16'h0000
                     : {second_arith_reg_r, accumulator_r} % {8'h00, offset_reg_r};

  // Accumulator, second register and offset register with results.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      accumulator_r <= psm_pkg::RST_BYTE;
      second_arith_reg_r <= psm_pkg::RST_BYTE;
      offset_reg_r <= psm_pkg::RST_BYTE;
    end else if (cmd_go && cmd == psm_pkg::CMD_MUL) begin
      {offset_reg_r, second_arith_reg_r, accumulator_r} <= product;
    end else if (cmd_go && cmd == psm_pkg::CMD_DIV) begin
      {second_arith_reg_r, accumulator_r} <= quotient;
      offset_reg_r <= remainder[7:0];
    end else if (state_r == psm_pkg::ST_ROM_FIN) begin
      accumulator_r <= rom_rdata;
    end else if (state_r == psm_pkg::ST_EXT_FIN) begin
      accumulator_r <= ext_rdata;
    end else if (state_r == psm_pkg::ST_RAM_FIN) begin
      accumulator_r <= ram_rdata[7:0];
    end else if (wr_ok) begin
      if (idx == psm_pkg::IDX_ACC) accumulator_r <= avs_writedata[7:0];
      if (idx == psm_pkg::IDX_SAR) second_arith_reg_r <= avs_writedata[7:0];
      if (idx == psm_pkg::IDX_OFFS) offset_reg_r <= avs_writedata[7:0];
    end
  end

  // Status word: ninth RAM bit and overflow are updated by the sequencer.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_word_r <= psm_pkg::RST_BYTE;
    end else if (state_r == psm_pkg::ST_RAM_FIN) begin
      status_word_r[psm_pkg::ST_P1] <= ram_rdata[8];
    end else if (cmd_go && cmd == psm_pkg::CMD_MUL) begin
      status_word_r[psm_pkg::ST_OV] <= (product[23:16] != 8'h00);
    end else if (cmd_go && cmd == psm_pkg::CMD_DIV) begin
      status_word_r[psm_pkg::ST_OV] <= (offset_reg_r == 8'h00);
    end else if (wr_ok && idx == psm_pkg::IDX_STATUS) begin
      status_word_r <= avs_writedata[7:0];
    end
  end

  // Operand register for targets, offsets and addresses.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oper_r <= 24'h000000;
    end else if (wr_ok && idx == psm_pkg::IDX_OPER) begin
      oper_r <= avs_writedata[23:0];
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  property p_step;
    @(posedge clock) disable iff (!rst_b)
    (cmd_go && cmd == psm_pkg::CMD_STEP) |=> (pc_r == $past(pc_r) + $past(len))
      && (bank_select_flag_r == $past(bank_select_flag_r));
  endproperty
  a_step: assert property (p_step) else $error("Step moved counter wrongly.");

  property p_intr;
    @(posedge clock) disable iff (!rst_b)
    (cmd_go && cmd == psm_pkg::CMD_INTR && oper_r[3:0] < psm_pkg::NUM_VEC)
      |=> (pc_r == $past(vec)) && !bank_select_flag_r ##1 ram_we;
  endproperty
  a_intr: assert property (p_intr) else $error("Interrupt vector not taken.");

  property p_br12;
    @(posedge clock) disable iff (!rst_b)
    (cmd_go && cmd == psm_pkg::CMD_BR12) |=> pc_r == $past(pc_r) + psm_pkg::REL12_LEN + $past(rel12);
  endproperty
  a_br12: assert property (p_br12) else $error("Relative branch target wrong.");

  property p_push;
    @(posedge clock) disable iff (!rst_b)
    (state_r == psm_pkg::ST_PUSH_LO) |-> ram_we && ram_addr == sp_r + 16'h0001
      ##1 ram_we && ram_wdata == ret_r[16:8] ##1 sp_r == $past(sp_r, 2) + 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("Stack save sequence wrong.");

  property p_pop;
    @(posedge clock) disable iff (!rst_b)
    (state_r == psm_pkg::ST_POP_HI) |-> ram_addr == sp_r ##1 ram_addr == $past(sp_r) - 16'h0001
      ##2 sp_r == $past(sp_r, 3) - 16'h0002;
  endproperty
  a_pop: assert property (p_pop) else $error("Stack restore order wrong.");

  property p_ret_bank;
    @(posedge clock) disable iff (!rst_b)
    (state_r == psm_pkg::ST_POP_FIN) |=> bank_select_flag_r == $past(ram_rdata[8])
      && pc_r[7:0] == $past(ram_rdata[7:0]);
  endproperty
  a_ret_bank: assert property (p_ret_bank) else $error("Return bank wrong.");

  property p_lookup;
    @(posedge clock) disable iff (!rst_b)
    rom_re |-> rom_addr[psm_pkg::ROM_AW-1] == bank_select_flag_r ##1 state_r == psm_pkg::ST_ROM_FIN;
  endproperty
  a_lookup: assert property (p_lookup) else $error("Lookup left the bank.");

  property p_ext;
    @(posedge clock) disable iff (!rst_b)
    (ext_re || ext_we) |-> ext_addr[23:16] == second_arith_reg_r;
  endproperty
  a_ext: assert property (p_ext) else $error("External address top byte wrong.");

  property p_ram9;
    @(posedge clock) disable iff (!rst_b)
    (state_r == psm_pkg::ST_RAM_WR) |-> ram_addr <= psm_pkg::RAM9_TOP
      && ram_wdata[8] == status_word_r[psm_pkg::ST_P1];
  endproperty
  a_ram9: assert property (p_ram9) else $error("Nine-bit write wrong.");

endmodule
`default_nettype wire

// [verification/psm_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psm_mem_model (
  // Clock.
  input wire logic clock,
  // Program ROM side; a byte is its address bits 7:0 xor bits 17:10.
  input wire logic [17:0] rom_addr,
  input wire logic rom_re,
  output logic [7:0] rom_rdata,
  // Nine-bit data RAM side with one cycle of read latency.
  input wire logic [15:0] ram_addr,
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic [8:0] ram_wdata,
  output logic [8:0] ram_rdata
);
  logic [8:0] mem [0:65535];
  // Data is valid only the cycle after a strobe; otherwise it toggles so stale use shows.
  always @(posedge clock) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    rom_rdata <= rom_re ? (rom_addr[7:0] ^ rom_addr[17:10]) : ~rom_rdata;
    ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
  end
endmodule
`default_nettype wire

// [verification/test_psm_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_psm_sequencer;
  // ****************************************************************
  // Stimulus, responses and counters.
  // ****************************************************************
  logic clock = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [17:0] avs_address = 18'h00000, rom_addr;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, rom_re, ram_re, ram_we, ext_re, ext_we;
  logic [15:0] ram_addr;
  logic [8:0] ram_wdata, ram_rdata;
  logic [23:0] ext_addr;
  logic [7:0] rom_rdata, ext_wdata;
  int num_errors = 0, n_tests = 0;
  // External data reads return a fixed byte.
  psm_sequencer i_dut (.clock, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .rom_addr, .rom_re, .rom_rdata, .ram_addr, .ram_re, .ram_we,
    .ram_wdata, .ram_rdata, .ext_addr, .ext_re, .ext_we, .ext_wdata, .ext_rdata(8'h5c));
  psm_mem_model i_mem (.clock, .rom_addr, .rom_re, .rom_rdata, .ram_addr, .ram_re, .ram_we,
    .ram_wdata, .ram_rdata);
  logic [31:0] ext_seen = 32'h0;
  // Records the address and byte of each external store as the far side sees them.
  always @(posedge clock) begin
    if (ext_we) begin
      ext_seen <= {ext_addr, ext_wdata};
    end
  end
  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clock = ~clock;
  end
  // Prints the counts and the verdict.
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] register %h expected %h seen %h", idx, e, g);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      num_errors++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rc(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(idx, e, rd);
  endtask
  // Issues a command, then an ignored write that stalls until the sequencer is idle.
  task automatic cmd(input psm_pkg::psm_cmd_t c, input logic [2:0] len, input logic tk);
    wr(psm_pkg::IDX_CMD, 32'({tk, len, c}));
    wr(16'h0000, 32'h0);
  endtask
  task automatic ramw(input logic [15:0] a, input logic [8:0] d);
    wr(psm_pkg::IDX_STATUS, {30'h0, d[8], 1'b0});
    wr(psm_pkg::IDX_ACC, {24'h0, d[7:0]});
    wr(psm_pkg::IDX_OPER, {16'h0, a});
    cmd(psm_pkg::CMD_RAMWR, 3'h0, 1'b0);
  endtask
  task automatic t_regs();
    rc(psm_pkg::IDX_ACC, 32'h0);
    rc(psm_pkg::IDX_SAR, 32'h0);
    rc(psm_pkg::IDX_PC, 32'h0);
    wr(psm_pkg::IDX_SAR, 32'h3c);
    rc(psm_pkg::IDX_SAR, 32'h3c);
    rc(16'h1234, 32'h0);
  endtask
  task automatic t_flow();
    wr(psm_pkg::IDX_OPER, 32'h1fffe);
    cmd(psm_pkg::CMD_JUMP, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h1fffe);
    rc(psm_pkg::IDX_CMD, 32'h2);
    cmd(psm_pkg::CMD_STEP, 3'h3, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h1);
    wr(psm_pkg::IDX_OPER, 32'hfe);
    cmd(psm_pkg::CMD_BRCOND, 3'h2, 1'b1);
    rc(psm_pkg::IDX_PC, 32'h1);
    cmd(psm_pkg::CMD_BRCOND, 3'h2, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h3);
    wr(psm_pkg::IDX_OPER, 32'h800);
    cmd(psm_pkg::CMD_BR12, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h1f805);
    wr(psm_pkg::IDX_ACC, 32'hff);
    cmd(psm_pkg::CMD_CALLA, 3'h1, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h1f905);
  endtask
  // Bank switch by a prepared return, then a call, its saved bytes and a return.
  task automatic t_stack();
    ramw(16'h0011, 9'h134);
    ramw(16'h0012, 9'h012);
    wr(psm_pkg::IDX_SPL, 32'h12);
    cmd(psm_pkg::CMD_RET, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h21234);
    rc(psm_pkg::IDX_SPL, 32'h10);
    wr(psm_pkg::IDX_OPER, 32'h500);
    cmd(psm_pkg::CMD_CALL, 3'h3, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h20500);
    rc(psm_pkg::IDX_SPL, 32'h12);
    wr(psm_pkg::IDX_OPER, 32'h11);
    cmd(psm_pkg::CMD_RAMRD, 3'h0, 1'b0);
    rc(psm_pkg::IDX_ACC, 32'h37);
    rc(psm_pkg::IDX_STATUS, 32'h2);
    cmd(psm_pkg::CMD_RET, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h21237);
    wr(psm_pkg::IDX_OPER, 32'h1);
    cmd(psm_pkg::CMD_INTR, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h0000b);
    wr(psm_pkg::IDX_OPER, 32'h9);
    cmd(psm_pkg::CMD_INTR, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h0004b);
    wr(psm_pkg::IDX_OPER, 32'ha);
    cmd(psm_pkg::CMD_INTR, 3'h0, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h0004b);
    wr(psm_pkg::IDX_OPER, 32'hfff);
    cmd(psm_pkg::CMD_CALL12, 3'h2, 1'b0);
    rc(psm_pkg::IDX_PC, 32'h0004c);
  endtask
  // Pointer 2 holds 9'h156 and 8'h78; the ROM byte at 18'h15678 is 8'h2d.
  task automatic t_misc();
    ramw(16'h0004, 9'h078);
    ramw(16'h0005, 9'h156);
    wr(psm_pkg::IDX_OPER, 32'h2);
    cmd(psm_pkg::CMD_LOOKUP, 3'h0, 1'b0);
    rc(psm_pkg::IDX_ACC, 32'h2d);
    wr(psm_pkg::IDX_SAR, 32'h01);
    wr(psm_pkg::IDX_ACC, 32'h02);
    wr(psm_pkg::IDX_OFFS, 32'h03);
    cmd(psm_pkg::CMD_MUL, 3'h0, 1'b0);
    rc(psm_pkg::IDX_ACC, 32'h06);
    rc(psm_pkg::IDX_SAR, 32'h03);
    rc(psm_pkg::IDX_OFFS, 32'h00);
    wr(psm_pkg::IDX_OFFS, 32'h04);
    cmd(psm_pkg::CMD_DIV, 3'h0, 1'b0);
    rc(psm_pkg::IDX_ACC, 32'hc1);
    rc(psm_pkg::IDX_SAR, 32'h00);
    rc(psm_pkg::IDX_OFFS, 32'h02);
    wr(psm_pkg::IDX_SAR, 32'hab);
    wr(psm_pkg::IDX_OPER, 32'h1234);
    rc(psm_pkg::IDX_XADDR, 32'hab1234);
    cmd(psm_pkg::CMD_XLOAD, 3'h0, 1'b0);
    rc(psm_pkg::IDX_ACC, 32'h5c);
    cmd(psm_pkg::CMD_XSTORE, 3'h0, 1'b0);
    chk(psm_pkg::IDX_XADDR, 32'hab12345c, ext_seen);
  endtask
  // Reset for six cycles, then the scenarios in order.
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_flow();
    t_stack();
    t_misc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
